//--- core/stop_recovery_defs.svh
// Register offsets, field positions, reset values and timing counts of the stop and supply block.
`ifndef STOP_RECOVERY_DEFS_SVH
`define STOP_RECOVERY_DEFS_SVH
`define CLK_HZ 10000000
`define IDX_STOP_RECOVERY 12'h00b
`define IDX_VOLTAGE_DETECT 12'h00c
`define OFF_STOP_RECOVERY (`IDX_STOP_RECOVERY << 2)
`define OFF_VOLTAGE_DETECT (`IDX_VOLTAGE_DETECT << 2)
`define OFF_IRQ_STATUS 12'h040
`define OFF_MASK 12'h044
`define OFF_WATCHDOG_MODE 12'h048
`define OFF_STOP_CTRL 12'h04c
`define SRC_FLAG_BIT 7
`define SRC_POL_BIT 6
`define SRC_DELAY_BIT 5
`define SRC_SEL_LSB 2
`define SRC_SEL_MSB 4
`define SRC_DIV_BIT 0
`define SRC_RESET 8'h00
`define DET_HIGH_BIT 2
`define DET_LOW_BIT 1
`define DET_EN_BIT 0
`define IRQ_SUPPLY_BIT 5
`define WDM_STOP_BIT 3
`define WDM_RESET 8'h08
`define DET_SETTLE_US 20
`define DET_SETTLE_CYC ((`DET_SETTLE_US * `CLK_HZ + 999999) / 1000000)
`define DIV_RATIO 16
`define SHORT_DELAY_CYC 5
`define LONG_DELAY_CYC 64
`define POR_SEQ_CYC 128
`endif

//--- core/stop_recovery_pkg.sv
// Types shared by the stop recovery and supply detection block.
package stop_recovery_pkg;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_STOP = 2'b01,
    PWR_WAKE_DELAY = 2'b10,
    PWR_BROWNOUT = 2'b11
  } pwr_state_t;
endpackage

//--- core/stop_recovery_voltage_detect.sv
// Stop mode recovery control, clock prescaler, brown-out reset and supply detection.
//
// Contract
// - Stop recovery bit 7 reads only; hardware sets it on recovery; power-on clears.
// - Bit 6 picks low or high level of the wake source.
// - Bit 5 picks the reset delay applied after recovery.
// - Bits 4..2 pick which source ends stop mode.
// - Bit 0 enables divide-by-16 on core and timer clocks.
// - Every stop recovery clears the divide-by-16 select bit.
// - Watchdog-during-stop bit keeps watchdog counting in stop; defaults to 1.
// - Watchdog in stop runs from the internal RC clock.
// - Brown-out comparator low forces global reset.
// - Supply restored runs a full power-on sequence, then resumes.
// - Voltage detect bit 0 enables monitoring; resets to 0.
// - Supply flags are invalid for 20 us after enabling detection.
// - Bit 2 high flag follows high comparator; resets 0.
// - Bit 1 low flag follows low comparator; resets 0.
// - Low flag with detection on latches interrupt bit 5 until cleared.
// - Latched request raises interrupt only when its mask bit is set.
`timescale 1ns/1ns
`default_nettype none
`include "stop_recovery_defs.svh"
module stop_recovery_voltage_detect
  import stop_recovery_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and comparators.
  input wire logic [7:0] wake_sources,
  input wire logic brownout_low,
  input wire logic supply_above_high,
  input wire logic supply_below_low,
  input wire logic stop_request,
  // Clock enables and status.
  output logic core_clk_en,
  output logic timer_interrupt_clock_en,
  output logic global_reset,
  output logic in_stop,
  output logic watchdog_rc_select,
  output logic watchdog_run,
  output logic supply_interrupt
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pins pass three stages; a change is taken once the last two agree.
  localparam int NIN = 12;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;
  logic [NIN-1:0] pin_reg;
  assign pin_raw = {stop_request, supply_below_low, supply_above_high, brownout_low,
                    wake_sources};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < NIN; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          pin_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  logic [7:0] wake_in;
  logic bo_in;
  logic hi_in;
  logic lo_in;
  logic stop_in;
  assign wake_in = pin_reg[7:0];
  assign bo_in = pin_reg[8];
  assign hi_in = pin_reg[9];
  assign lo_in = pin_reg[10];
  assign stop_in = pin_reg[11];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic recovered_reg;
  logic wake_pol_reg;
  logic delay_sel_reg;
  logic [2:0] src_sel_reg;
  logic div16_reg;
  logic det_en_reg;
  logic irq_reg;
  logic mask_reg;
  logic wdt_stop_reg;
  logic high_flag_reg;
  logic low_flag_reg;
  pwr_state_t state_reg;
  logic [7:0] cnt_reg;
  logic [7:0] settle_reg;
  logic [3:0] div_reg;

  logic wr;
  logic rd;
  logic hit;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign hit = (paddr == `OFF_STOP_RECOVERY) || (paddr == `OFF_VOLTAGE_DETECT) ||
               (paddr == `OFF_IRQ_STATUS) || (paddr == `OFF_MASK) ||
               (paddr == `OFF_WATCHDOG_MODE) || (paddr == `OFF_STOP_CTRL);

  logic wake_event;
  logic flags_valid;
  assign wake_event = (state_reg == PWR_STOP) &&
                      ((wake_in[src_sel_reg] ^ wake_pol_reg) == 1'b0);
  assign flags_valid = det_en_reg && (settle_reg == 8'h00);

  // Only power-on clears the recovered flag; the APB reset is the power-on path.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      recovered_reg <= 1'b0;
    end else if (wake_event) begin
      recovered_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_pol_reg <= 1'b0;
      delay_sel_reg <= 1'b0;
      src_sel_reg <= 3'h0;
      div16_reg <= 1'b0;
    end else if (state_reg == PWR_BROWNOUT) begin
      wake_pol_reg <= 1'b0;
      delay_sel_reg <= 1'b0;
      src_sel_reg <= 3'h0;
      div16_reg <= 1'b0;
    end else if (wake_event) begin
      div16_reg <= 1'b0;
    end else if (wr && paddr == `OFF_STOP_RECOVERY) begin
      wake_pol_reg <= pwdata[`SRC_POL_BIT];
      delay_sel_reg <= pwdata[`SRC_DELAY_BIT];
      src_sel_reg <= pwdata[`SRC_SEL_MSB:`SRC_SEL_LSB];
      div16_reg <= pwdata[`SRC_DIV_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      det_en_reg <= 1'b0;
      mask_reg <= 1'b0;
      wdt_stop_reg <= 1'b1;
    end else if (state_reg == PWR_BROWNOUT) begin
      det_en_reg <= 1'b0;
      mask_reg <= 1'b0;
      wdt_stop_reg <= 1'b1;
    end else if (wr) begin
      if (paddr == `OFF_VOLTAGE_DETECT) begin
        det_en_reg <= pwdata[`DET_EN_BIT];
      end
      if (paddr == `OFF_MASK) begin
        mask_reg <= pwdata[`IRQ_SUPPLY_BIT];
      end
      if (paddr == `OFF_WATCHDOG_MODE) begin
        wdt_stop_reg <= pwdata[`WDM_STOP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Supply detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 8'h00;
    end else if (!det_en_reg) begin
      settle_reg <= 8'(`DET_SETTLE_CYC);
    end else if (settle_reg != 8'h00) begin
      settle_reg <= settle_reg - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      high_flag_reg <= 1'b0;
      low_flag_reg <= 1'b0;
    end else begin
      high_flag_reg <= flags_valid && hi_in;
      low_flag_reg <= flags_valid && lo_in;
    end
  end

  // A new low-supply event wins over a software clear in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else if (state_reg == PWR_BROWNOUT) begin
      irq_reg <= 1'b0;
    end else if (det_en_reg && low_flag_reg) begin
      irq_reg <= 1'b1;
    end else if (wr && paddr == `OFF_IRQ_STATUS && pwdata[`IRQ_SUPPLY_BIT]) begin
      irq_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PWR_RUN;
      cnt_reg <= 8'h00;
    end else if (bo_in) begin
      state_reg <= PWR_BROWNOUT;
      cnt_reg <= 8'(`POR_SEQ_CYC);
    end else begin
      unique case (state_reg)
        PWR_RUN: begin
          if (stop_in || (wr && paddr == `OFF_STOP_CTRL && pwdata[0])) begin
            state_reg <= PWR_STOP;
          end
        end
        PWR_STOP: begin
          if (wake_event) begin
            state_reg <= PWR_WAKE_DELAY;
            cnt_reg <= delay_sel_reg ? 8'(`LONG_DELAY_CYC) : 8'(`SHORT_DELAY_CYC);
          end
        end
        PWR_WAKE_DELAY, PWR_BROWNOUT: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= PWR_RUN;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // One tick per divider wrap gives the divide-by-16 rate; no gated clock is made.
  logic div_tick;
  assign div_tick = (div_reg == 4'(`DIV_RATIO - 1));

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en <= 1'b0;
      timer_interrupt_clock_en <= 1'b0;
      global_reset <= 1'b1;
      in_stop <= 1'b0;
      watchdog_rc_select <= 1'b0;
      watchdog_run <= 1'b1;
      supply_interrupt <= 1'b0;
    end else begin
      core_clk_en <= (state_reg == PWR_RUN) && (!div16_reg || div_tick);
      timer_interrupt_clock_en <= (state_reg != PWR_STOP) && (state_reg != PWR_BROWNOUT) &&
                                  (!div16_reg || div_tick);
      global_reset <= bo_in || (state_reg == PWR_BROWNOUT) ||
                      (state_reg == PWR_WAKE_DELAY);
      in_stop <= (state_reg == PWR_STOP);
      watchdog_rc_select <= (state_reg == PWR_STOP) && wdt_stop_reg;
      watchdog_run <= (state_reg != PWR_STOP) || wdt_stop_reg;
      supply_interrupt <= irq_reg && mask_reg;
    end
  end

  // ----------------------------------------------------------------
  // Read views of the registers
  // ----------------------------------------------------------------
  // Write-only fields are left out of the views, so they always read back as zero.
  logic [7:0] src_view;
  logic [7:0] det_view;
  logic [7:0] irq_view;
  logic [7:0] mask_view;
  logic [7:0] wdm_view;
  always_comb begin
    src_view = 8'h00;
    src_view[`SRC_FLAG_BIT] = recovered_reg;
    det_view = 8'h00;
    det_view[`DET_HIGH_BIT] = high_flag_reg;
    det_view[`DET_LOW_BIT] = low_flag_reg;
    det_view[`DET_EN_BIT] = det_en_reg;
    irq_view = 8'h00;
    irq_view[`IRQ_SUPPLY_BIT] = irq_reg;
    mask_view = 8'h00;
    mask_view[`IRQ_SUPPLY_BIT] = mask_reg;
    wdm_view = 8'h00;
    wdm_view[`WDM_STOP_BIT] = wdt_stop_reg;
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero with an error
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd) begin
        unique case (paddr)
          `OFF_STOP_RECOVERY: prdata <= {24'h0, src_view};
          `OFF_VOLTAGE_DETECT: prdata <= {24'h0, det_view};
          `OFF_IRQ_STATUS: prdata <= {24'h0, irq_view};
          `OFF_MASK: prdata <= {24'h0, mask_view};
          `OFF_WATCHDOG_MODE: prdata <= {24'h0, wdm_view};
          `OFF_STOP_CTRL: prdata <= {30'h0, state_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- sim/stop_recovery_voltage_detect_properties.sv
// Port-level concurrent checks for the stop recovery and supply detection block.
`timescale 1ns/1ns
`default_nettype none
module stop_recovery_voltage_detect_properties (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Bus handshake and brown-out input.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic brownout_low,
  // Clock enables and status.
  input wire logic core_clk_en,
  input wire logic timer_interrupt_clock_en,
  input wire logic global_reset,
  input wire logic in_stop,
  input wire logic watchdog_rc_select,
  input wire logic watchdog_run
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // A lone enable pulse outside reset and stop can only come from the prescaler.
  sequence lone_pulse;
    !core_clk_en ##1 core_clk_en ##1 (!core_clk_en && !global_reset && !in_stop);
  endsequence
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("setup not answered in the first access cycle");
  AST_APB_ONLY_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  AST_APB_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_BROWNOUT_RESET: assert property (brownout_low |-> ##[0:6] global_reset)
    else $error("brown-out did not drive global reset");
  AST_POR_SEQUENCE: assert property ($fell(brownout_low) && global_reset |-> global_reset[*8])
    else $error("global reset dropped at once after supply return");
  AST_DIV16_GAP: assert property (lone_pulse |=> !core_clk_en[*8])
    else $error("divided clock enable came too soon");
  // The timer enable may run while reset holds the core, so they match only outside it.
  AST_CLOCKS_TOGETHER: assert property (!global_reset |->
    core_clk_en == timer_interrupt_clock_en)
    else $error("core and timer enables differ");
  AST_RC_IN_STOP: assert property (in_stop && watchdog_run && $past(in_stop, 2) |-> watchdog_rc_select)
    else $error("watchdog not on the RC clock in stop");
  AST_WAKE_RESET: assert property ($fell(in_stop) |-> ##[0:2] global_reset)
    else $error("leaving stop without a reset delay");
endmodule
bind stop_recovery_voltage_detect stop_recovery_voltage_detect_properties
  stop_recovery_voltage_detect_properties_inst (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .brownout_low(brownout_low),
  .core_clk_en(core_clk_en), .timer_interrupt_clock_en(timer_interrupt_clock_en),
  .global_reset(global_reset), .in_stop(in_stop), .watchdog_rc_select(watchdog_rc_select),
  .watchdog_run(watchdog_run));
`default_nettype wire

//--- sim/stop_recovery_voltage_detect_tb.sv
// Self-checking bench for the stop recovery and supply detection block.
`timescale 1ns/1ns
`default_nettype none
`include "stop_recovery_defs.svh"
module stop_recovery_voltage_detect_tb;
  logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, brownout_low = 0;
  logic supply_above_high = 0, supply_below_low = 0, stop_request = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] wake_sources = 0;
  logic pready, pslverr, core_clk_en, timer_en, global_reset, in_stop, wd_rc, wd_run, sup_irq;
  logic [33:0] nt;
  logic [33:0] notes[$];
  int fail_count = 0, samples_checked = 0;
  stop_recovery_voltage_detect stop_recovery_voltage_detect_inst (.clk_sys(clk_sys),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_sources(wake_sources), .brownout_low(brownout_low),
    .supply_above_high(supply_above_high), .supply_below_low(supply_below_low),
    .stop_request(stop_request), .core_clk_en(core_clk_en),
    .timer_interrupt_clock_en(timer_en), .global_reset(global_reset), .in_stop(in_stop),
    .watchdog_rc_select(wd_rc), .watchdog_run(wd_run), .supply_interrupt(sup_irq));
  always #50 clk_sys = ~clk_sys;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task timeout(input string what);
    fail_count++;
    $display("[FAIL] %s expected answer seen timeout", what);
    conclude();
  endtask
  // The note carries {compare data, expected error, expected data}.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] note);
    int k;
    notes.push_back(note);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) timeout("pready");
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 34'h0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0, {2'b10, e});
  endtask
  task wait_gr(input logic lvl, output int n);
    n = 0;
    while (global_reset !== lvl) begin
      @(posedge clk_sys);
      n++;
      if (n > 400) timeout("global_reset");
    end
  endtask
  task pulses(input int cyc, output int n, output int t);
    n = 0;
    t = 0;
    // Skip the edge whose enables still reflect the divider setting before the write.
    @(posedge clk_sys);
    repeat (cyc) begin
      @(posedge clk_sys);
      n += core_clk_en;
      t += timer_en;
    end
  endtask
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) check("note", 1, 0);
      else begin
        nt = notes.pop_front();
        check("pslverr", pslverr, nt[32]);
        if (nt[33]) check("prdata", prdata, nt[31:0]);
      end
    end
  end
  initial begin
    int n, t, sel;
    logic pol;
    logic [7:0] ctrl_val;
    void'($urandom(32'h0c7d));
    repeat (12) @(posedge clk_sys);
    rstn <= 1;
    repeat (4) @(posedge clk_sys);
    rd(`OFF_STOP_RECOVERY, 32'h0);
    rd(`OFF_VOLTAGE_DETECT, 32'h0);
    rd(`OFF_WATCHDOG_MODE, `WDM_RESET);
    apb(0, 12'h0f0, 0, {2'b11, 32'h0});
    apb(1, 12'h0f0, $urandom, {2'b01, 32'h0});
    wr(`OFF_VOLTAGE_DETECT, $urandom & 32'hfe);
    rd(`OFF_VOLTAGE_DETECT, 32'h0);
    wr(`OFF_STOP_RECOVERY, $urandom & 32'h7e);
    rd(`OFF_STOP_RECOVERY, 32'h0);
    brownout_low <= 1;
    repeat (8) @(posedge clk_sys);
    check("global_reset", global_reset, 1);
    brownout_low <= 0;
    wait_gr(0, n);
    check("por_len", n >= `POR_SEQ_CYC && n <= `POR_SEQ_CYC + 8, 1);
    // The high comparator is driven along with the low one while the low supply condition is watched.
    supply_below_low <= 1;
    supply_above_high <= 1;
    wr(`OFF_MASK, 32'h20);
    wr(`OFF_VOLTAGE_DETECT, 32'h1);
    rd(`OFF_VOLTAGE_DETECT, 32'h1);
    repeat (`DET_SETTLE_CYC - 10) @(posedge clk_sys);
    rd(`OFF_VOLTAGE_DETECT, 32'h1);
    repeat (15) @(posedge clk_sys);
    rd(`OFF_VOLTAGE_DETECT, 32'h7);
    rd(`OFF_IRQ_STATUS, 32'h20);
    check("supply_interrupt", sup_irq, 1);
    supply_below_low <= 0;
    repeat (8) @(posedge clk_sys);
    rd(`OFF_VOLTAGE_DETECT, 32'h5);
    rd(`OFF_IRQ_STATUS, 32'h20);
    wr(`OFF_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    check("supply_interrupt", sup_irq, 0);
    wr(`OFF_IRQ_STATUS, 32'h20);
    rd(`OFF_IRQ_STATUS, 32'h0);
    supply_above_high <= 0;
    wr(`OFF_VOLTAGE_DETECT, 32'h0);
    for (int i = 0; i < 2; i++) begin
      sel = $urandom_range(7);
      pol = $urandom;
      ctrl_val = {1'b0, pol, !i[0], sel[2:0], 2'b01};
      wake_sources <= pol ? ~(8'h1 << sel) : (8'h1 << sel);
      wr(`OFF_WATCHDOG_MODE, i ? 32'h0 : 32'h8);
      wr(`OFF_STOP_RECOVERY, {24'h0, ctrl_val});
      pulses(64, n, t);
      check("core_pulses", n, 4);
      check("timer_pulses", t, 4);
      if (i) stop_request <= 1;
      else wr(`OFF_STOP_CTRL, 32'h1);
      repeat (10) @(posedge clk_sys);
      stop_request <= 0;
      check("in_stop", in_stop, 1);
      check("watchdog_run", wd_run, !i);
      check("watchdog_rc", wd_rc, !i);
      wake_sources <= wake_sources ^ (8'h1 << sel);
      wait_gr(1, n);
      wait_gr(0, n);
      check("wake_delay", n, i ? `SHORT_DELAY_CYC + 1 : `LONG_DELAY_CYC + 1);
      check("in_stop", in_stop, 0);
      rd(`OFF_STOP_RECOVERY, 32'h80);
      pulses(16, n, t);
      check("undivided", n, 16);
    end
    // A second power-on must clear the recovery flag and restore the watchdog default.
    rstn <= 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1;
    repeat (4) @(posedge clk_sys);
    rd(`OFF_STOP_RECOVERY, 32'h0);
    rd(`OFF_WATCHDOG_MODE, `WDM_RESET);
    conclude();
  end
endmodule
`default_nettype wire
